// >>> inc/caf_map.svh
// register offsets, field positions and reset values of the acceptance filter
// Overview of operation
// [RULE1] A received extended identifier bit 15..0 matches when it equals the filter bit.
// [RULE2] A one in mask standard bits 15..5 compares that standard identifier bit, a zero ignores it.
// [RULE3] With the type match mode bit (bit 3) set, only frames whose type agrees with the filter's extended select pass.
// [RULE4] With the type match mode clear, a standard frame matches on the standard bits and an extended one on all bits.
// [RULE5] Mask standard bits 1 and 0 include or ignore extended identifier bits 17 and 16.
// [RULE6] Each mask extended bit includes or ignores extended identifier bit 15..0.
// [RULE7] Mask standard bits 4 and 2 read as zero and ignore writes.
// [RULE8] A two-bit source field of 00, 01, 10 picks mask set 0, 1, 2; 11 is reserved.
// [RULE9] Filter k's source field sits at bits 2k+1..2k of the low select register.
// [RULE10] A filter matches only when every enabled bit agrees and the type condition holds.
`ifndef CAF_MAP_SVH
`define CAF_MAP_SVH

`define CAF_ADDR_W        5
`define CAF_FEID_BASE     5'h00
`define CAF_MASK_BASE     5'h10
`define CAF_MSEL_LOW      5'h18
`define CAF_MATCH_STAT    5'h19
`define CAF_MSID_IMPL     16'hFFEB
`define CAF_MSID_SID_LSB  5
`define CAF_MSID_MODE_BIT 3
`define CAF_REG_RESET     16'h0000
`define CAF_MSEL_RESET    16'h0000
`define CAF_NUM_MASKS     3

`endif

// >>> inc/caf_pkg.sv
// types shared by the acceptance filter modules
`default_nettype none
package caf_pkg;
	typedef logic [15:0] caf_word_t;
	typedef logic [10:0] caf_sid_t;
	typedef logic [17:0] caf_eid_t;
	typedef enum logic [1:0]
	{
		CAF_SRC_MASK0,
		CAF_SRC_MASK1,
		CAF_SRC_MASK2,
		CAF_SRC_RSVD
	} caf_mask_src_t;
endpackage
`default_nettype wire

// >>> rtl/caf_mask_set.sv
// one acceptance mask set: standard and extended mask registers
`include "caf_map.svh"
`default_nettype none
module caf_mask_set
	import caf_pkg::*;
(
	input  wire logic      clk_in,
	input  wire logic      rst_n_in,
	input  wire logic      wr_sid_in,
	input  wire logic      wr_eid_in,
	input  wire caf_word_t wr_data_in,
	output caf_word_t      msid_out,
	output caf_word_t      meid_out
);
	// unimplemented bits never store, so they read back zero
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			msid_out <= `CAF_REG_RESET;
		else if (wr_sid_in)
			msid_out <= wr_data_in & `CAF_MSID_IMPL; // [RULE7]
	end

	// extended mask, all 16 bits live
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			meid_out <= `CAF_REG_RESET;
		else if (wr_eid_in)
			meid_out <= wr_data_in;
	end

	unimpl_zero_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
		msid_out[4] == 1'b0 && msid_out[2] == 1'b0) // [RULE7]
		else $error("unimplemented mask bit holds a one");
endmodule
`default_nettype wire

// >>> rtl/caf_filter_cmp.sv
// masked identifier compare for one filter
`include "caf_map.svh"
`default_nettype none
module caf_filter_cmp
	import caf_pkg::*;
(
	input  wire caf_sid_t      rx_sid_in,
	input  wire caf_eid_t      rx_eid_in,
	input  wire logic          rx_ext_in,
	input  wire caf_sid_t      filt_sid_in,
	input  wire caf_eid_t      filt_eid_in,
	input  wire logic          filt_ext_sel_in,
	input  wire caf_mask_src_t src_in,
	input  wire caf_word_t     msid_in,
	input  wire caf_word_t     meid_in,
	output logic               hit_out
);
	caf_sid_t sid_care;
	caf_eid_t eid_care;
	logic     sid_ok;
	logic     eid_ok;
	logic     type_mode;

	// mask bits pick which identifier bits take part
	assign sid_care  = msid_in[15:`CAF_MSID_SID_LSB];                // [RULE2]
	assign eid_care  = {msid_in[1:0], meid_in};                 // [RULE5] [RULE6]
	assign sid_ok    = ((rx_sid_in ^ filt_sid_in) & sid_care) == '0;
	assign eid_ok    = ((rx_eid_in ^ filt_eid_in) & eid_care) == '0; // [RULE1]
	assign type_mode = msid_in[`CAF_MSID_MODE_BIT];

	// reserved source never matches, so software slips stay harmless
	always_comb
	begin
		hit_out = 1'b0;
		if (src_in != CAF_SRC_RSVD)                                 // [RULE8]
		begin
			if (type_mode && (rx_ext_in != filt_ext_sel_in))       // [RULE3]
				hit_out = 1'b0;
			else if (rx_ext_in)
				hit_out = sid_ok && eid_ok;                         // [RULE4]
			else
				hit_out = sid_ok;                                   // [RULE10]
		end
	end
endmodule
`default_nettype wire

// >>> rtl/caf_accept_top.sv
// acceptance filter and mask logic with its register port
`include "caf_map.svh"
`default_nettype none
module caf_accept_top
	import caf_pkg::*;
#(
	parameter int NUM_FILT = 8
)
(
	input  wire logic                     sys_clk_in,
	input  wire logic                     rst_n_in,
	input  wire logic [`CAF_ADDR_W-1:0]   addr_in,
	input  wire caf_word_t                wr_data_in,
	input  wire logic                     wr_strobe_in,
	input  wire logic                     rd_strobe_in,
	output caf_word_t                     rd_data_out,
	input  wire logic                     rx_valid_in,
	input  wire caf_sid_t                 rx_sid_in,
	input  wire caf_eid_t                 rx_eid_in,
	input  wire logic                     rx_ext_in,
	input  wire logic [NUM_FILT*11-1:0]   filt_sid_in,
	input  wire logic [NUM_FILT*2-1:0]    filt_eid_hi_in,
	input  wire logic [NUM_FILT-1:0]      filt_ext_sel_in,
	output logic [NUM_FILT-1:0]           match_out,
	output logic                          match_valid_out
);
	logic          rst_sync1;
	logic          rst_n;
	caf_word_t     filt_eid_lo [NUM_FILT];
	caf_word_t     mask_sel;
	caf_word_t     msid [`CAF_NUM_MASKS];
	caf_word_t     meid [`CAF_NUM_MASKS];
	caf_word_t     sel_msid [NUM_FILT];
	caf_word_t     sel_meid [NUM_FILT];
	caf_mask_src_t src [NUM_FILT];
	logic [NUM_FILT-1:0] next_match;
	logic          is_mask;
	logic [1:0]    mask_idx;
	caf_word_t     next_rd;

	// reset asserts at once and releases through two flops
	always_ff @(posedge sys_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			rst_sync1 <= 1'b0;
			rst_n     <= 1'b0;
		end
		else
		begin
			rst_sync1 <= 1'b1;
			rst_n     <= rst_sync1;
		end
	end

	// address decode for the three mask sets
	assign is_mask  = addr_in[4:3] == 2'b10;
	assign mask_idx = addr_in[2:1];

	// filter extended identifier bits, one word per filter
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int k = 0; k < NUM_FILT; k++)
				filt_eid_lo[k] <= `CAF_REG_RESET;
		end
		else if (wr_strobe_in && addr_in < 5'(NUM_FILT))
			filt_eid_lo[addr_in[2:0]] <= wr_data_in;
	end

	// mask source select for filters 0..7
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			mask_sel <= `CAF_MSEL_RESET;
		else if (wr_strobe_in && addr_in == `CAF_MSEL_LOW)
			mask_sel <= wr_data_in;
	end

	// mask sets live in their own module, one instance each
	for (genvar m = 0; m < `CAF_NUM_MASKS; m++)
	begin : g_mask
		caf_mask_set u_set
		(
			.clk_in     (sys_clk_in),
			.rst_n_in   (rst_n),
			.wr_sid_in  (wr_strobe_in && is_mask && mask_idx == 2'(m)
				&& !addr_in[0]),
			.wr_eid_in  (wr_strobe_in && is_mask && mask_idx == 2'(m)
				&& addr_in[0]),
			.wr_data_in (wr_data_in),
			.msid_out   (msid[m]),
			.meid_out   (meid[m])
		);
	end

	// per filter: pick the mask set and compare
	for (genvar k = 0; k < NUM_FILT; k++)
	begin : g_filt
		assign src[k] = caf_mask_src_t'(mask_sel[2*k+1:2*k]); // [RULE9]
		// reserved code falls back to set 0 here; the compare rejects it
		assign sel_msid[k] = (src[k] == CAF_SRC_MASK1) ? msid[1] :
			(src[k] == CAF_SRC_MASK2) ? msid[2] : msid[0];     // [RULE8]
		assign sel_meid[k] = (src[k] == CAF_SRC_MASK1) ? meid[1] :
			(src[k] == CAF_SRC_MASK2) ? meid[2] : meid[0];
		caf_filter_cmp u_cmp
		(
			.rx_sid_in       (rx_sid_in),
			.rx_eid_in       (rx_eid_in),
			.rx_ext_in       (rx_ext_in),
			.filt_sid_in     (filt_sid_in[11*k+10:11*k]),
			.filt_eid_in     ({filt_eid_hi_in[2*k+1:2*k], filt_eid_lo[k]}),
			.filt_ext_sel_in (filt_ext_sel_in[k]),
			.src_in          (src[k]),
			.msid_in         (sel_msid[k]),
			.meid_in         (sel_meid[k]),
			.hit_out         (next_match[k])
		);
	end

	// result stands for one cycle after each received identifier
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
		begin
			match_out       <= '0;
			match_valid_out <= 1'b0;
		end
		else
		begin
			match_valid_out <= rx_valid_in;
			match_out       <= rx_valid_in ? next_match : '0; // [RULE10]
		end
	end

	// sticky copy of the last match vector for software to inspect
	logic [NUM_FILT-1:0] last_match;
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			last_match <= '0;
		else if (match_valid_out)
			last_match <= match_out;
	end

	// read mux; unmapped addresses answer zero
	always_comb
	begin
		next_rd = '0;
		if (addr_in < 5'(NUM_FILT))
			next_rd = filt_eid_lo[addr_in[2:0]];
		else if (is_mask && mask_idx != 2'b11)
			next_rd = addr_in[0] ? meid[mask_idx] : msid[mask_idx]; // [RULE7]
		else if (addr_in == `CAF_MSEL_LOW)
			next_rd = mask_sel;
		else if (addr_in == `CAF_MATCH_STAT)
			next_rd = 16'(last_match);
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk_in or negedge rst_n)
	begin
		if (!rst_n)
			rd_data_out <= '0;
		else if (rd_strobe_in)
			rd_data_out <= next_rd;
		else
			rd_data_out <= '0;
	end

	// checks on filter 0 against its selected mask set
	caf_word_t m0s;
	caf_word_t m0e;
	assign m0s = sel_msid[0];
	assign m0e = sel_meid[0];

	sequence s_rx_ext;
		rx_valid_in && rx_ext_in;
	endsequence

	sequence s_rx_std;
		rx_valid_in && !rx_ext_in;
	endsequence

	sequence s_sel_write;
		wr_strobe_in && addr_in == `CAF_MSEL_LOW;
	endsequence

	sequence s_mask_read;
		rd_strobe_in && is_mask && !addr_in[0] && mask_idx != 2'b11;
	endsequence

	eid_low_miss_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		s_rx_ext ##0 ((rx_eid_in[15:0] ^ filt_eid_lo[0]) & m0e) != '0
		|=> !match_out[0]) // [RULE1] [RULE6]
		else $error("filter 0 hit despite extended bit mismatch");

	sid_miss_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		rx_valid_in && ((rx_sid_in ^ filt_sid_in[10:0])
		& m0s[15:`CAF_MSID_SID_LSB]) != '0 |=> !match_out[0]) // [RULE2]
		else $error("filter 0 hit despite standard bit mismatch");

	type_mode_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		rx_valid_in && m0s[`CAF_MSID_MODE_BIT]
		&& rx_ext_in != filt_ext_sel_in[0] |=> !match_out[0]) // [RULE3]
		else $error("filter 0 hit on wrong frame type");

	std_any_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		s_rx_std ##0 !m0s[`CAF_MSID_MODE_BIT] && src[0] != CAF_SRC_RSVD
		&& ((rx_sid_in ^ filt_sid_in[10:0]) & m0s[15:5]) == '0
		|=> match_out[0]) // [RULE4]
		else $error("standard frame missed with type mode clear");

	eid_high_miss_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		s_rx_ext ##0 ((rx_eid_in[17:16] ^ filt_eid_hi_in[1:0]) & m0s[1:0])
		!= 2'b00 |=> !match_out[0]) // [RULE5]
		else $error("filter 0 hit despite bit 17/16 mismatch");

	mask_read_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		s_mask_read |=> rd_data_out[4] == 1'b0 && rd_data_out[2] == 1'b0
		##1 rd_data_out == '0 || $past(rd_strobe_in)) // [RULE7]
		else $error("unimplemented mask bit read as one");

	reserved_src_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		rx_valid_in && src[0] == CAF_SRC_RSVD |=> !match_out[0]) // [RULE8]
		else $error("reserved mask source produced a hit");

	sel_field_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		s_sel_write |=> src[0] == caf_mask_src_t'($past(wr_data_in[1:0]))
		&& src[7] == caf_mask_src_t'($past(wr_data_in[15:14]))) // [RULE9]
		else $error("mask source field not at its bit position");

	result_time_a: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
		!rx_valid_in |=> !match_valid_out && match_out == '0) // [RULE10]
		else $error("match shown without a received identifier");

	// a taken identifier always gets its answer on the next edge
	valid_follow_a: assert property (@(posedge sys_clk_in) // [RULE10]
		disable iff (!rst_n)
		rx_valid_in |=> match_valid_out)
		else $error("no match result after a received identifier");

	// extended frame with every enabled bit equal must hit
	ext_full_a: assert property (@(posedge sys_clk_in) // [RULE4]
		disable iff (!rst_n)
		s_rx_ext ##0 !m0s[`CAF_MSID_MODE_BIT] && src[0] != CAF_SRC_RSVD
		&& ((rx_sid_in ^ filt_sid_in[10:0]) & m0s[15:5]) == '0
		&& ((rx_eid_in[15:0] ^ filt_eid_lo[0]) & m0e) == '0
		&& ((rx_eid_in[17:16] ^ filt_eid_hi_in[1:0]) & m0s[1:0]) == 2'b00
		|=> match_out[0])
		else $error("extended frame missed with all enabled bits equal");

	// a select write lands whole, field positions included
	sel_store_a: assert property (@(posedge sys_clk_in) // [RULE9]
		disable iff (!rst_n)
		s_sel_write |=> mask_sel == $past(wr_data_in))
		else $error("mask select write did not land");

	// read back of a standard mask shows only implemented bits
	mask_readback_a: assert property (@(posedge sys_clk_in) // [RULE7]
		disable iff (!rst_n)
		s_mask_read |=> rd_data_out
		== ($past(msid[mask_idx]) & `CAF_MSID_IMPL))
		else $error("standard mask read back wrong");

	// every filter, not just filter 0, obeys the miss conditions and the standard frame hit
	for (genvar k = 0; k < NUM_FILT; k++)
	begin : g_chk
		rsvd_any_a: assert property (@(posedge sys_clk_in) // [RULE8]
			disable iff (!rst_n)
			rx_valid_in && src[k] == CAF_SRC_RSVD |=> !match_out[k])
			else $error("reserved mask source produced a hit");

		type_any_a: assert property (@(posedge sys_clk_in) // [RULE3]
			disable iff (!rst_n)
			rx_valid_in && sel_msid[k][`CAF_MSID_MODE_BIT]
			&& rx_ext_in != filt_ext_sel_in[k] |=> !match_out[k])
			else $error("filter hit on the wrong frame type");

		sid_any_a: assert property (@(posedge sys_clk_in) // [RULE2]
			disable iff (!rst_n)
			rx_valid_in && ((rx_sid_in ^ filt_sid_in[11*k+10:11*k])
			& sel_msid[k][15:`CAF_MSID_SID_LSB]) != '0
			|=> !match_out[k])
			else $error("filter hit despite standard bit mismatch");

		eid_any_a: assert property (@(posedge sys_clk_in) // [RULE6]
			disable iff (!rst_n)
			s_rx_ext ##0 ((rx_eid_in[15:0] ^ filt_eid_lo[k])
			& sel_meid[k]) != '0 |=> !match_out[k])
			else $error("filter hit despite extended bit mismatch");

		eidh_any_a: assert property (@(posedge sys_clk_in) // [RULE5]
			disable iff (!rst_n)
			s_rx_ext ##0 ((rx_eid_in[17:16]
			^ filt_eid_hi_in[2*k+1:2*k]) & sel_msid[k][1:0]) != 2'b00
			|=> !match_out[k])
			else $error("filter hit despite bit 17/16 mismatch");

		std_hit_a: assert property (@(posedge sys_clk_in) // [RULE4]
			disable iff (!rst_n)
			s_rx_std ##0 !sel_msid[k][`CAF_MSID_MODE_BIT]
			&& src[k] != CAF_SRC_RSVD
			&& ((rx_sid_in ^ filt_sid_in[11*k+10:11*k])
			& sel_msid[k][15:`CAF_MSID_SID_LSB]) == '0
			|=> match_out[k])
			else $error("standard frame missed with type mode clear");
	end
endmodule
`default_nettype wire

// >>> dv/caf_rx_model.sv
// protocol engine stand-in presenting one received identifier per frame
`default_nettype none
module caf_rx_model
	import caf_pkg::*;
(
	input  wire logic clk_in,
	output logic      rx_valid_out,
	output caf_sid_t  rx_sid_out,
	output caf_eid_t  rx_eid_out,
	output logic      rx_ext_out
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet link at time zero
	initial
	begin
		rx_valid_out = 1'b0;
		rx_sid_out   = '0;
		rx_eid_out   = '0;
		rx_ext_out   = 1'b0;
	end

	// one frame: held for the taking edge, then the ids scramble
	// so a stale identifier can never pass for a fresh one
	task automatic send(input caf_sid_t s, input caf_eid_t e,
		input logic x);
		rx_valid_out <= 1'b1;
		rx_sid_out   <= s;
		rx_eid_out   <= e;
		rx_ext_out   <= x;
		@(posedge clk_in);
		rx_valid_out <= 1'b0;
		rx_sid_out   <= ~s;
		rx_eid_out   <= ~e;
		rx_ext_out   <= ~x;
	endtask
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// self-checking bench for the acceptance filter block
`include "caf_map.svh"
`default_nettype none
module tb_top import caf_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;

	logic        sys_clk;
	logic        rst_n  = 1'b0;
	logic        wr_stb = 1'b0;
	logic        rd_stb = 1'b0;
	logic [4:0]  addr   = 5'h00;
	caf_word_t   wdata  = 16'h0000;
	caf_word_t   rdata;
	logic        rx_valid;
	caf_sid_t    rx_sid;
	caf_eid_t    rx_eid;
	logic        rx_ext;
	// filter 4 differs in its standard id, filter 6 wants extended frames
	logic [87:0] f_sid  = {{3{11'h5A5}}, 11'h5A4, {4{11'h5A5}}};
	logic [15:0] f_hi   = 16'hAAAA;
	logic [7:0]  f_ext  = 8'h40;
	logic [7:0]  match;
	logic        mv;
	int          n_errors = 0;
	int          compares = 0;

	caf_accept_top #(.NUM_FILT(8)) i_caf_accept_top (
		.sys_clk_in(sys_clk), .rst_n_in(rst_n), .addr_in(addr),
		.wr_data_in(wdata), .wr_strobe_in(wr_stb),
		.rd_strobe_in(rd_stb), .rd_data_out(rdata),
		.rx_valid_in(rx_valid), .rx_sid_in(rx_sid), .rx_eid_in(rx_eid),
		.rx_ext_in(rx_ext), .filt_sid_in(f_sid), .filt_eid_hi_in(f_hi),
		.filt_ext_sel_in(f_ext), .match_out(match),
		.match_valid_out(mv));

	caf_rx_model i_caf_rx_model (
		.clk_in(sys_clk), .rx_valid_out(rx_valid), .rx_sid_out(rx_sid),
		.rx_eid_out(rx_eid), .rx_ext_out(rx_ext));

	// 250 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic complete_run();
		if (n_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input string name, input caf_word_t seen,
		input caf_word_t exp);
		compares++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// leading edge keeps a strobe low for a cycle between accesses
	task automatic wr(input logic [4:0] a, input caf_word_t d);
		@(posedge sys_clk);
		addr   <= a;
		wdata  <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [4:0] a, input caf_word_t exp);
		@(posedge sys_clk);
		addr   <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1;
		chk("read data", rdata, exp);
	endtask

	// one frame, then the one-cycle answer
	task automatic frame(input caf_sid_t s, input caf_eid_t e,
		input logic x, input logic [7:0] exp);
		@(posedge sys_clk);
		i_caf_rx_model.send(s, e, x);
		#1;
		chk("match valid", {15'h0000, mv}, 16'h0001);
		chk("match vector", {8'h00, match}, {8'h00, exp});
	endtask

	// run limit
	initial
	begin
		#100000;
		n_errors++;
		complete_run();
	end

	initial
	begin
		repeat (5) @(posedge sys_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge sys_clk);
		rd(`CAF_MSEL_LOW, 16'h0000);
		for (int k = 0; k < 8; k++)
			wr(k[4:0], 16'h3C3C);
		rd(5'h07, 16'h3C3C);
		wr(5'h10, 16'hFFFF);
		rd(5'h10, 16'hFFEB);
		wr(5'h10, 16'hFFE3);
		wr(5'h11, 16'hFFFF);
		wr(5'h12, 16'h0000);
		wr(5'h13, 16'h0000);
		wr(5'h14, 16'hFFEB);
		wr(5'h15, 16'hFFFF);
		wr(5'h16, 16'h1234);
		rd(5'h16, 16'h0000);
		// sources 00,01,10,11,00,01,10,10 for filters 0..7
		wr(`CAF_MSEL_LOW, 16'hA4E4);
		rd(`CAF_MSEL_LOW, 16'hA4E4);
		frame(11'h5A5, 18'h23C3C, 1'b1, 8'h63);
		frame(11'h5A5, 18'h00000, 1'b0, 8'hA7);
		frame(11'h5A5, 18'h23C3D, 1'b1, 8'h22);
		wr(5'h11, 16'hFFFE);
		frame(11'h5A5, 18'h23C3D, 1'b1, 8'h23);
		frame(11'h5A5, 18'h03C3C, 1'b1, 8'h22);
		wr(5'h10, 16'hFFE0);
		frame(11'h5A5, 18'h03C3C, 1'b1, 8'h23);
		frame(11'h5A4, 18'h00000, 1'b0, 8'h32);
		wr(5'h10, 16'hFFC0);
		frame(11'h5A4, 18'h00000, 1'b0, 8'h33);
		rd(`CAF_MATCH_STAT, 16'h0033);
		complete_run();
	end
endmodule
`default_nettype wire
